/* design/flash_bus_host.sv */
// Purpose: Host controller driving a parallel flash through its pins
// Assumes: One clock; flash data and ready pins asynchronous, synchronised here
// Notes: Software issues one read, write or hardware reset at a time via CTRL
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_host
	import flash_bus_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Software register port
	input wire sw_req_t sw,
	output logic [31:0] rdata,
	// Flash control and address
	output flash_ctl_t ctl,
	output logic [AW-1:0] addr,
	output logic elev_reset_req,
	output logic elev_id_req,
	// Flash data, split two-way pins; oe low means driving
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic [DATA_W-1:0] dq_oe_n,
	// Flash ready pin
	input wire logic ready_busy_n
);
	typedef enum {S_IDLE, S_RSETUP, S_RWAIT, S_WSETUP, S_WPULSE, S_WHOLD, S_RST} state_t;
	state_t state;
	logic [3:0] cnt;
	logic [AW-1:0] addr_reg;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rd_data;
	logic [4:0] mode;
	logic busy;
	logic timeout_seen;
	logic toggle_prev;
	logic toggle_change;
	logic [DATA_W-1:0] dq_s1, dq_s2;
	logic rb_s1, rb_s2;
	logic [3:0] stable_cnt;
	logic asleep;
	logic start_rd, start_wr, start_rst;

	assign start_rd = sw.wr && sw.addr == REG_CTRL && sw.wdata[1:0] == CMD_READ && !busy;
	assign start_wr = sw.wr && sw.addr == REG_CTRL && sw.wdata[1:0] == CMD_WRITE && !busy;
	assign start_rst = sw.wr && sw.addr == REG_CTRL && sw.wdata[1:0] == CMD_RESET && !busy;
	assign busy = state != S_IDLE;

	// Two-flop synchronisers on the flash pins, nothing reads stage one
	always_ff @(posedge clk) begin
		if (srst) begin
			dq_s1 <= '0;
			dq_s2 <= '0;
			rb_s1 <= 1'b1;
			rb_s2 <= 1'b1;
		end else begin
			dq_s1 <= dq_in;
			dq_s2 <= dq_s1;
			rb_s1 <= ready_busy_n;
			rb_s2 <= rb_s1;
		end
	end

	// Software-written registers
	always_ff @(posedge clk) begin
		if (srst) begin
			addr_reg <= '0;
			wdata <= '0;
			mode <= 5'h01;
		end else if (sw.wr) begin
			unique case (sw.addr)
				REG_ADDR: addr_reg <= sw.wdata[AW-1:0];
				REG_WDATA: wdata <= sw.wdata[DATA_W-1:0];
				REG_MODE: mode <= sw.wdata[4:0];
				default: ;
			endcase
		end
	end

	// Bus sequencer: read, write and hardware-reset cycles
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= S_IDLE;
			cnt <= '0;
		end else begin
			unique case (state)
				S_IDLE: begin
					cnt <= '0;
					if (start_rd) state <= S_RSETUP;
					else if (start_wr) state <= S_WSETUP;
					else if (start_rst) state <= S_RST;
				end
				S_RSETUP: state <= S_RWAIT;
				S_RWAIT: begin
					// Two extra cycles cover the data synchroniser delay
					cnt <= cnt + 4'h1;
					if (cnt == ACC_CYC + 4'h1) state <= S_IDLE;
				end
				S_WSETUP: begin
					cnt <= cnt + 4'h1;
					if (cnt == SU_CYC - 4'h1) begin
						cnt <= '0;
						state <= S_WPULSE;
					end
				end
				S_WPULSE: begin
					cnt <= cnt + 4'h1;
					if (cnt == WP_CYC - 4'h1) state <= S_WHOLD;
				end
				S_WHOLD: state <= S_IDLE;
				S_RST: begin
					cnt <= cnt + 4'h1;
					if (cnt == RST_CYC - 4'h1) state <= S_IDLE;
				end
			endcase
		end
	end

	// Capture read data at the end of the access; status bits tracked
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_data <= '0;
			toggle_prev <= 1'b0;
			toggle_change <= 1'b0;
			timeout_seen <= 1'b0;
		end else if (state == S_RWAIT && cnt == ACC_CYC + 4'h1) begin
			// Byte mode reads only the low lane, upper lanes float except lane 15, which carries the byte address
			rd_data <= mode[MODE_WORD] ? dq_s2 : {{(DATA_W-BYTE_W){1'b0}}, dq_s2[BYTE_W-1:0]};
			toggle_change <= dq_s2[TOGGLE_BIT] != toggle_prev;
			toggle_prev <= dq_s2[TOGGLE_BIT];
			// Set wins over a clear in the same cycle
			timeout_seen <= dq_s2[TIMEOUT_BIT] | (timeout_seen & ~start_rst);
		end else if (start_rst) begin
			timeout_seen <= 1'b0;
		end
	end

	// Address-stable counter models when the flash has gone to sleep
	always_ff @(posedge clk) begin
		if (srst || start_rd || start_wr) stable_cnt <= '0;
		else if (stable_cnt != SLEEP_CYC) stable_cnt <= stable_cnt + 4'h1;
	end
	assign asleep = stable_cnt == SLEEP_CYC;

	// Pin drivers; output enable never low during a write
	always_ff @(posedge clk) begin
		if (srst) begin
			ctl <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1, reset_n: 1'b0,
				word_mode: 1'b1};
			addr <= '0;
			dq_out <= '0;
			dq_oe_n <= '1;
		end else begin
			ctl.word_mode <= mode[MODE_WORD];
			ctl.reset_n <= state != S_RST;
			ctl.chip_sel_n <= !(state inside {S_RSETUP, S_RWAIT, S_WSETUP, S_WPULSE, S_WHOLD})
				&& mode[MODE_STANDBY];
			ctl.out_en_n <= !(state inside {S_RSETUP, S_RWAIT});
			ctl.wr_en_n <= state != S_WPULSE;
			// Address held stable across the whole write, so both edges see it
			addr <= addr_reg;
			// Byte mode drives only the low lane; lane 15 carries the byte address
			dq_out <= mode[MODE_WORD] ? wdata : {{(DATA_W-BYTE_W){1'b0}}, wdata[BYTE_W-1:0]};
			if (state inside {S_WSETUP, S_WPULSE, S_WHOLD}) begin
				dq_oe_n <= mode[MODE_WORD] ? '0 : {{(DATA_W-BYTE_W){1'b1}}, {BYTE_W{1'b0}}};
			end else begin
				dq_oe_n <= '1;
			end
			if (!mode[MODE_WORD]) begin
				dq_out[LSB_LANE] <= addr_reg[0];
				dq_oe_n[LSB_LANE] <= 1'b0;
			end
		end
	end

	// Elevated levels requested from board circuitry
	assign elev_reset_req = mode[MODE_ELEV_RST];
	assign elev_id_req = mode[MODE_ELEV_ID];

	// Read port, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (srst) rdata <= '0;
		else if (sw.rd) begin
			unique case (sw.addr)
				REG_ADDR: rdata <= 32'(addr_reg);
				REG_WDATA: rdata <= 32'(wdata);
				REG_RDATA: rdata <= 32'(rd_data);
				REG_STATUS: rdata <= {26'h0, asleep, toggle_change, timeout_seen,
					rb_s2, ~rb_s2, busy};
				REG_MODE: rdata <= 32'(mode);
				default: rdata <= '0;
			endcase
		end else rdata <= '0;
	end

	// Write cycle keeps output enable high while write strobe is low
	a_write_oe_high: assert property (@(posedge clk) disable iff (srst)
		!ctl.wr_en_n |-> ctl.out_en_n && !ctl.chip_sel_n)
		else $error("write strobe with output enable low");
	// Write pulse lasts exactly its programmed width
	a_write_pulse_len: assert property (@(posedge clk) disable iff (srst)
		$fell(ctl.wr_en_n) |-> ##1 $rose(ctl.wr_en_n))
		else $error("write pulse wrong length");
	// Data stays driven past the rising strobe
	a_data_hold: assert property (@(posedge clk) disable iff (srst)
		$rose(ctl.wr_en_n) |-> dq_oe_n[0] == 1'b0)
		else $error("write data released at strobe rise");
	// Reset pulse stays low long enough
	a_reset_width: assert property (@(posedge clk) disable iff (srst)
		$fell(ctl.reset_n) |-> !ctl.reset_n [*8])
		else $error("hardware reset too short");
	// Lowest upper lane (lane 8) never driven during byte mode write pulses
	a_byte_lanes: assert property (@(posedge clk) disable iff (srst)
		!ctl.word_mode && !ctl.wr_en_n |-> dq_oe_n[BYTE_W] == 1'b1)
		else $error("upper lane driven in byte mode");
	// Address held through the write pulse
	a_addr_stable: assert property (@(posedge clk) disable iff (srst)
		!ctl.wr_en_n |-> $stable(addr))
		else $error("address moved during write");
	// Host releases lane 0 whenever output enable is asserted
	a_read_oe: assert property (@(posedge clk) disable iff (srst)
		!ctl.out_en_n |-> dq_oe_n[0] == 1'b1)
		else $error("host drives data while flash outputs");
	// Read completes within the access window
	a_read_done: assert property (@(posedge clk) disable iff (srst)
		start_rd |-> ##[4:8] state == S_IDLE)
		else $error("read cycle did not finish");
endmodule
`default_nettype wire

/* design/flash_bus_pkg.sv */
// Purpose: Constants and carrier types for the parallel flash bus controller
// Assumes: Flash pins are driven at logic levels; the elevated level is a request output
// Notes: Function list below, one line per behaviour
//
// Function
// - Host sends reset on timeout or leaving identification; here only on a CMD_RESET write, timeout just sets a status bit
// - Elevated identification needs selector and sector bits
// - Identification also entered by command write
// - Write: select and strobe low, enable high
// - Write data on low byte or all lanes
// - Elevated reset for protection; protect others first
package flash_bus_pkg;
	// Device pin geometry
	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int LSB_LANE = 15;
	// Bus timing at 25 MHz
	localparam int CLK_NS = 40;
	localparam int ACC_NS = 70;
	localparam int OE_NS = 30;
	localparam int SLEEP_EXTRA_NS = 30;
	localparam int RESET_LOW_NS = 500;
	localparam int SETUP_NS = 40;
	localparam int WPULSE_NS = 40;
	localparam logic [3:0] ACC_CYC = 4'((ACC_NS + CLK_NS - 1) / CLK_NS + 1);
	localparam logic [3:0] WP_CYC = 4'((WPULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] SU_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RST_CYC = 4'((RESET_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] SLEEP_CYC = 4'((ACC_NS + SLEEP_EXTRA_NS + CLK_NS - 1) / CLK_NS);
	// Status bit positions in read data
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int TIMEOUT_BIT = 5;
	// Register map, word addresses on the software port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_WDATA = 4'h2;
	localparam logic [3:0] REG_RDATA = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_MODE = 4'h5;
	// Control register commands
	localparam logic [1:0] CMD_READ = 2'h1;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_RESET = 2'h3;
	// Mode register fields
	localparam int MODE_WORD = 0;
	localparam int MODE_STANDBY = 1;
	localparam int MODE_ELEV_RST = 2;
	localparam int MODE_ELEV_ID = 3;

	// Control pins toward the flash, active low except word_mode
	typedef struct packed {
		logic chip_sel_n;
		logic out_en_n;
		logic wr_en_n;
		logic reset_n;
		logic word_mode;
	} flash_ctl_t;

	// Software port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} sw_req_t;
endpackage

/* verif/flash_model.sv */
// Purpose: Behavioural parallel flash seen from its pins
// Assumes: Sixteen words; words 8 to 15 form a protected sector
// Notes: Busy lasts 120 ns after each accepted write
`timescale 1ns/1ps
`default_nettype none
module flash_model
	import flash_bus_pkg::*;
(
	// Host side pins
	input wire flash_ctl_t ctl,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] dq_pins,
	input wire logic elev_reset_req,
	// Device drive
	output logic [DATA_W-1:0] dq_dev,
	output logic [DATA_W-1:0] dev_en,
	output logic ready_busy_n
);
	logic [15:0] mem [16];
	logic [3:0] wa;
	logic wcyc;
	logic on;
	wire cs_n = ctl.chip_sel_n;
	wire we_n = ctl.wr_en_n;
	// Preload so reads work with no command
	initial begin
		for (int i = 0; i < 16; i++)
			mem[i] = {8'h30 + 8'(i), 8'hc0 + 8'(i)};
		wcyc = 1'b0;
		ready_busy_n = 1'b1;
	end
	// Drive only in a full read cycle; upper lanes stay off in byte mode
	assign on = !cs_n && !ctl.out_en_n && we_n && ctl.reset_n;
	assign dev_en = {{8{on & ctl.word_mode}}, {8{on}}};
	// Output follows the address at once, so a stable address keeps it latched
	assign dq_dev = ctl.word_mode ? mem[addr[3:0]] :
		{8'h00, dq_pins[15] ? mem[addr[3:0]][15:8] : mem[addr[3:0]][7:0]};
	// Address taken at the later falling edge
	always @(negedge cs_n or negedge we_n) begin
		if (!cs_n && !we_n && ctl.out_en_n) begin
			wa = addr[3:0];
			wcyc = 1'b1;
		end
	end
	// Data taken at the first rising edge, then an internal busy spell
	always @(posedge cs_n or posedge we_n) begin
		if (wcyc) begin
			wcyc = 1'b0;
			if (!wa[3] || elev_reset_req) begin
				mem[wa] = ctl.word_mode ? dq_pins : {mem[wa][15:8], dq_pins[7:0]};
				ready_busy_n = 1'b0;
				ready_busy_n <= #120 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for the flash host controller
// Assumes: Flash model on the pins; software port driven here
// Notes: Expected words come from the preload formula
`timescale 1ns/1ps
`default_nettype none
module tb;
	import flash_bus_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	sw_req_t sw = '0;
	logic [31:0] rdata, s;
	flash_ctl_t ctl;
	logic [ADDR_W-1:0] addr;
	logic elev_reset_req, elev_id_req, ready_busy_n, float_pat = 1'b0;
	logic [DATA_W-1:0] dq_in, dq_out, dq_oe_n, dq_dev, dev_en;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	flash_bus_host i_dut (.clk(clk), .srst(srst), .sw(sw), .rdata(rdata), .ctl(ctl),
		.addr(addr), .elev_reset_req(elev_reset_req), .elev_id_req(elev_id_req),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ready_busy_n(ready_busy_n));
	flash_model i_flash (.ctl(ctl), .addr(addr), .dq_pins(dq_in),
		.elev_reset_req(elev_reset_req), .dq_dev(dq_dev), .dev_en(dev_en),
		.ready_busy_n(ready_busy_n));
	always #20 clk = ~clk;
	// A lane nobody drives changes every cycle, so stale data cannot pass
	always @(posedge clk) float_pat <= ~float_pat;
	always_comb begin
		for (int i = 0; i < DATA_W; i++)
			dq_in[i] = dev_en[i] ? dq_dev[i] : (!dq_oe_n[i] ? dq_out[i] : float_pat);
	end
	function automatic logic [31:0] init_val(int i);
		return {16'h0000, 8'h30 + 8'(i), 8'hc0 + 8'(i)};
	endfunction
	task automatic summarize();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic sw_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		sw <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		sw <= '0;
	endtask
	task automatic sw_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		sw <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		sw <= '0;
		#1 d = rdata;
	endtask
	// Poll until the controller is idle and the flash reports ready
	task automatic do_op(input logic [1:0] cmd);
		if (cmd != 2'h0)
			sw_wr(REG_CTRL, {30'h0, cmd});
		for (int i = 0; i < 60; i++) begin
			sw_rd(REG_STATUS, s);
			if (s[0] === 1'b0 && s[2] === 1'b1)
				break;
		end
		chk("idle ready", 32'h4, s & 32'h5);
	endtask
	task automatic f_rd(input logic [3:0] a, output logic [31:0] d);
		sw_wr(REG_ADDR, {28'h0, a});
		do_op(CMD_READ);
		sw_rd(REG_RDATA, d);
	endtask
	task automatic f_wr(input logic [3:0] a, input logic [15:0] d);
		sw_wr(REG_ADDR, {28'h0, a});
		sw_wr(REG_WDATA, {16'h0, d});
		do_op(CMD_WRITE);
	endtask
	task automatic t_reset();
		sw_rd(REG_MODE, s);
		chk("mode reset", 32'h1, s);
		sw_rd(4'hf, s);
		chk("unmapped", 32'h0, s);
		f_rd(4'h2, s);
		chk("first read", init_val(2), s);
	endtask
	task automatic t_word();
		f_wr(4'h6, 16'ha55a);
		f_rd(4'h6, s);
		chk("word rw", 32'ha55a, s);
	endtask
	task automatic t_byte();
		sw_wr(REG_MODE, 32'h0);
		f_rd(4'h7, s);
		chk("byte hi", init_val(7) >> 8, s & 32'hff);
		f_wr(4'h4, 16'h003c);
		f_rd(4'h4, s);
		chk("byte rw", 32'h3c, s & 32'hff);
		sw_wr(REG_MODE, 32'h1);
		f_rd(4'h4, s);
		chk("word after byte", (init_val(4) & 32'hff00) | 32'h3c, s);
	endtask
	task automatic t_protect();
		f_wr(4'h9, 16'h1234);
		f_rd(4'h9, s);
		chk("locked", init_val(9), s);
		sw_wr(REG_MODE, 32'h5);
		#1 chk("elevated req", 32'h1, {31'h0, elev_reset_req});
		f_wr(4'h9, 16'h1234);
		f_rd(4'h9, s);
		chk("unlocked", 32'h1234, s);
		sw_wr(REG_MODE, 32'h1);
		f_wr(4'h9, 16'h5678);
		f_rd(4'h9, s);
		chk("relocked", 32'h1234, s);
	endtask
	task automatic t_standby();
		sw_wr(REG_MODE, 32'h3);
		repeat (2) @(posedge clk);
		#1 chk("standby cs", 32'h1, {31'h0, ctl.chip_sel_n});
		f_rd(4'h3, s);
		chk("standby read", init_val(3), s);
		sw_wr(REG_MODE, 32'h1);
	endtask
	task automatic t_hw_reset();
		sw_wr(REG_CTRL, {30'h0, CMD_RESET});
		for (int i = 0; i < 6 && ctl.reset_n !== 1'b0; i++)
			@(posedge clk);
		#1 chk("reset pin", 32'h0, {31'h0, ctl.reset_n});
		do_op(2'h0);
		f_rd(4'h1, s);
		chk("read after reset", init_val(1), s);
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_word();
		t_byte();
		t_protect();
		t_standby();
		t_hw_reset();
		summarize();
	end
endmodule
`default_nettype wire
